//--- rtl/host_port_pkg.sv
// Overview of operation
// RULE_01: Host decoder drives select to choose device.
// RULE_02: Select may be tied to data strobe.
// RULE_03: Space select high memory, low registers.
// RULE_04: 16-bit buffered, polarity low: low means read.
// RULE_05: Otherwise direction high means read, low write.
// RULE_06: Buffer enable low during host access.
// RULE_07: Buffered mode host may omit external buffers.
// RULE_08: Nonzero-wait read ready once data valid.
// RULE_09: Nonzero-wait write ready once data stored.
// RULE_10: Zero-wait handshake high after strobe rises.
// RULE_11: Style bit clear gives 500 ns low pulse.
// RULE_12: Style bit set gives low interrupt level.
// RULE_13: Strap high transparent, low buffered operation.
// RULE_14: Width select high 16-bit, low 8-bit. Code ignores width select in transparent mode and always uses 16-bit there.
// RULE_15: Host times each transfer with data strobe.
// RULE_16: Device synchronizes all asynchronous host inputs.
// RULE_17: Pulse width counted in nearest clock cycles.
`default_nettype none
package host_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int INT_PULSE_NS = 500;
  localparam int INT_PULSE_CYC =
    (INT_PULSE_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int PULSE_W = $clog2(INT_PULSE_CYC + 1);
  localparam int DEV_WAIT_CYC = 2;
  localparam int DEV_XFER_CYC = 4;
  localparam int CNT_W = 8;
  // Device register indices on the host port, space select low.
  localparam logic [ADDR_W-1:0] REG_CONFIG1 = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CONFIG2 = 8'h01;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h03;
  localparam int CFG2_INT_LEVEL_BIT = 3;
  localparam logic [DATA_W-1:0] DEV_REG_RST = 16'h0000;
  // Controller register word addresses.
  localparam logic [2:0] HOST_CTRL = 3'h0;
  localparam logic [2:0] HOST_ADDR = 3'h1;
  localparam logic [2:0] HOST_WDATA = 3'h2;
  localparam logic [2:0] HOST_RDATA = 3'h3;
  localparam logic [2:0] HOST_STATUS = 3'h4;
  localparam logic [2:0] HOST_INT_STATUS = 3'h5;
  localparam logic [2:0] HOST_INT_MASK = 3'h6;
  localparam logic [2:0] HOST_CFG = 3'h7;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_MEM_BIT = 2;
  localparam int CFG_TRANSPARENT_BIT = 0;
  localparam int CFG_WIDE_BIT = 1;
  localparam int CFG_POLARITY_BIT = 2;
  localparam int CFG_ZERO_WAIT_BIT = 3;
  localparam int HINT_DONE_BIT = 0;
  localparam int HINT_DEV_BIT = 1;
  localparam logic [3:0] HOST_CFG_RST = 4'h6;
  localparam logic [2:0] HOST_CTRL_RST = 3'h0;
  localparam int HOST_ZW_STROBE_CYC = 8;

  function automatic logic is_read(input logic rd_wr, input logic polarity,
                                   input logic transparent, input logic wide);
    logic b16;
    b16 = ~transparent & wide;
    is_read = (b16 & ~polarity) ? ~rd_wr : rd_wr;
  endfunction
endpackage
`default_nettype wire

//--- rtl/host_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface host_port_if;
  import host_port_pkg::*;
  logic select_n;
  logic data_strobe_n;
  logic mem_reg;
  logic rd_wr;
  logic polarity_sel;
  logic width_sel;
  logic host_mode;
  logic zero_wait;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_dout;
  logic host_oe;
  logic [DATA_W-1:0] dev_dout;
  logic dev_oe;
  logic [DATA_W-1:0] data;
  logic buffer_drive_enable_n;
  logic transfer_handshake;
  logic int_n;

  // Resolved data lines; undriven lines float high.
  assign data = host_oe ? host_dout : (dev_oe ? dev_dout : '1);

  modport host(output select_n, data_strobe_n, mem_reg, rd_wr, polarity_sel,
               width_sel, host_mode, zero_wait, addr, host_dout, host_oe,
               input data, buffer_drive_enable_n, transfer_handshake, int_n);
  modport device(input select_n, data_strobe_n, mem_reg, rd_wr, polarity_sel,
                 width_sel, host_mode, zero_wait, addr, data,
                 output dev_dout, dev_oe, buffer_drive_enable_n,
                 transfer_handshake, int_n);
endinterface
`default_nettype wire

//--- rtl/host_port_device.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module host_port_device
  import host_port_pkg::*;
#(
  parameter int WAIT_CYC = DEV_WAIT_CYC,
  parameter int XFER_CYC = DEV_XFER_CYC,
  parameter int IRQ_W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  host_port_if.device bus,
  input wire logic [IRQ_W-1:0] irq_event,
  output logic [DATA_W-1:0] config2,
  output logic access_done
);
  localparam int SW = 8 + ADDR_W + DATA_W;

  typedef enum logic [2:0] {
    D_IDLE, D_WAIT, D_READY, D_ZW_HOLD, D_ZW_BUSY
  } dev_state_e;

  if (WAIT_CYC < 1 || WAIT_CYC >= 2 ** CNT_W ||
      XFER_CYC < 1 || XFER_CYC >= 2 ** CNT_W) begin : g_bad_cyc
    $error("Wait or transfer cycle count out of range.");
  end
  if (IRQ_W < 1 || IRQ_W >= DATA_W) begin : g_bad_irq
    $error("Interrupt width out of range.");
  end

  logic [SW-1:0] raw;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic sel_n_s;
  logic strb_n_s;
  logic mem_s;
  logic rd_wr_s;
  logic pol_s;
  logic wide_s;
  logic transparent_s;
  logic zero_wait_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  assign raw = {bus.select_n, bus.data_strobe_n, bus.mem_reg, bus.rd_wr,
                bus.polarity_sel, bus.width_sel, bus.host_mode,
                bus.zero_wait, bus.addr, bus.data};

  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= raw[i]; // RULE_16
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign {sel_n_s, strb_n_s, mem_s, rd_wr_s, pol_s, wide_s, transparent_s,
          zero_wait_s, addr_s, data_s} = sync_q;

  // Select and strobe are simply both required low, so one host signal
  // wired to both pins works as well.
  wire access = ~sel_n_s & ~strb_n_s; // RULE_02
  wire zw_mode = ~transparent_s & zero_wait_s; // RULE_13
  wire req_read = is_read(rd_wr_s, pol_s, transparent_s, wide_s); // RULE_04 RULE_05

  dev_state_e state_q;
  dev_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic mem_q;
  logic rd_q;
  logic wide_q;
  logic [DATA_W-1:0] rdata_q;
  logic load;
  logic xfer;
  logic [DATA_W-1:0] mem [2 ** ADDR_W];
  logic [DATA_W-1:0] cfg1_q;
  logic [DATA_W-1:0] cfg2_q;
  logic [IRQ_W-1:0] int_stat_q;
  logic [IRQ_W-1:0] int_mask_q;
  logic [PULSE_W-1:0] pulse_q;
  logic [PULSE_W-1:0] pulse_d;
  logic int_n_q;
  logic hs_q;
  logic hs_d;
  logic oe_q;
  logic oe_d;
  logic buf_en_n_q;
  logic done_q;

  always_comb begin
    state_d = state_q;
    load = 1'b0;
    xfer = 1'b0;
    case (state_q)
      D_IDLE: begin
        if (access) begin
          load = 1'b1;
          state_d = zw_mode ? D_ZW_HOLD : D_WAIT;
        end
      end
      D_WAIT: begin
        if (cnt_q == CNT_W'(WAIT_CYC - 1)) begin
          xfer = 1'b1; // RULE_08 RULE_09
          state_d = D_READY;
        end
      end
      D_READY: begin
        if (!access) begin
          state_d = D_IDLE;
        end
      end
      D_ZW_HOLD: begin
        if (!access) begin
          state_d = D_ZW_BUSY;
        end
      end
      D_ZW_BUSY: begin
        if (cnt_q == CNT_W'(XFER_CYC - 1)) begin
          xfer = 1'b1;
          state_d = D_IDLE;
        end
      end
      default: begin
        state_d = D_IDLE;
      end
    endcase
  end

  assign cnt_d = (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);

  // Address decode of the latched access.
  wire [DATA_W-1:0] wval = wide_q ? wdata_q : {8'h00, wdata_q[7:0]}; // RULE_14
  wire do_write = xfer & ~rd_q;
  wire mem_wr = do_write & mem_q; // RULE_03
  wire reg_wr = do_write & ~mem_q;
  wire wr_cfg1 = reg_wr & (addr_q == REG_CONFIG1);
  wire wr_cfg2 = reg_wr & (addr_q == REG_CONFIG2);
  wire wr_stat = reg_wr & (addr_q == REG_INT_STATUS);
  wire wr_mask = reg_wr & (addr_q == REG_INT_MASK);
  wire [IRQ_W-1:0] stat_clr = wr_stat ? wval[IRQ_W-1:0] : '0;
  wire [DATA_W-1:0] reg_rd =
    (addr_q == REG_CONFIG1) ? cfg1_q :
    (addr_q == REG_CONFIG2) ? cfg2_q :
    (addr_q == REG_INT_STATUS) ? {{(DATA_W - IRQ_W){1'b0}}, int_stat_q} :
    (addr_q == REG_INT_MASK) ? {{(DATA_W - IRQ_W){1'b0}}, int_mask_q} :
    '0;
  wire [DATA_W-1:0] rd_word = mem_q ? mem[addr_q] : reg_rd; // RULE_03
  wire [DATA_W-1:0] rd_sized = wide_q ? rd_word : {8'h00, rd_word[7:0]};
  wire zw_read_load = (state_q == D_ZW_HOLD) & rd_q;

  // A new event sets its flag even when the same cycle clears it.
  wire [IRQ_W-1:0] int_stat_d = (int_stat_q & ~stat_clr) | irq_event;
  wire level_mode = cfg2_q[CFG2_INT_LEVEL_BIT];
  wire pending = |(int_stat_q & int_mask_q);
  wire new_event = |(irq_event & int_mask_q);

  always_comb begin
    pulse_d = pulse_q;
    if (new_event && !level_mode) begin
      pulse_d = PULSE_W'(INT_PULSE_CYC); // RULE_17
    end else if (pulse_q != '0) begin
      pulse_d = pulse_q - PULSE_W'(1);
    end
  end

  always_comb begin
    if (zw_mode) begin
      hs_d = (state_d == D_ZW_BUSY); // RULE_10
    end else begin
      hs_d = ~(state_d == D_READY); // RULE_08 RULE_09
    end
  end

  assign oe_d = rd_q & ((state_d == D_READY) |
                ((state_q == D_ZW_HOLD) & (state_d == D_ZW_HOLD)));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= D_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      mem_q <= 1'b0;
      rd_q <= 1'b0;
      wide_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (load) begin
        addr_q <= addr_s;
        wdata_q <= data_s;
        mem_q <= mem_s;
        rd_q <= req_read;
        wide_q <= transparent_s | wide_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (mem_wr) begin
      mem[addr_q] <= wval;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg1_q <= DEV_REG_RST;
      cfg2_q <= DEV_REG_RST;
      int_stat_q <= '0;
      int_mask_q <= '0;
    end else begin
      if (wr_cfg1) begin
        cfg1_q <= wval;
      end
      if (wr_cfg2) begin
        cfg2_q <= wval;
      end
      if (wr_mask) begin
        int_mask_q <= wval[IRQ_W-1:0];
      end
      int_stat_q <= int_stat_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
      pulse_q <= '0;
      int_n_q <= 1'b1;
      hs_q <= 1'b1;
      oe_q <= 1'b0;
      buf_en_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      if ((xfer && rd_q) || zw_read_load) begin
        rdata_q <= rd_sized;
      end
      pulse_q <= pulse_d;
      int_n_q <= level_mode ? ~pending : (pulse_d == '0); // RULE_11 RULE_12
      hs_q <= hs_d;
      oe_q <= oe_d;
      buf_en_n_q <= ~((state_d == D_WAIT) | (state_d == D_READY) |
                      (state_d == D_ZW_HOLD)); // RULE_06
      done_q <= xfer;
    end
  end

  assign bus.dev_dout = rdata_q;
  assign bus.dev_oe = oe_q;
  assign bus.transfer_handshake = hs_q;
  assign bus.buffer_drive_enable_n = buf_en_n_q;
  assign bus.int_n = int_n_q;
  assign config2 = cfg2_q;
  assign access_done = done_q;
endmodule
`default_nettype wire

//--- rtl/host_port_controller.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_controller
  import host_port_pkg::*;
#(
  parameter int STROBE_CYC = HOST_ZW_STROBE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  host_port_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq
);
  localparam int SW = 2 + DATA_W;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_STROBE, H_CAPTURE, H_RELEASE, H_ZW_HI, H_ZW_LO
  } host_state_e;

  if (STROBE_CYC < 6 || STROBE_CYC >= 2 ** CNT_W) begin : g_bad_strobe
    $error("Zero-wait strobe length out of range.");
  end

  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  wire [SW-1:0] raw = {bus.transfer_handshake, bus.int_n, bus.data};
  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end
  wire hs_s = sync_q[SW-1];
  wire int_n_s = sync_q[SW-2];
  wire [DATA_W-1:0] data_s = sync_q[DATA_W-1:0];

  host_state_e state_q;
  host_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] int_stat_q;
  logic [1:0] int_mask_q;
  logic [3:0] cfg_q;
  logic int_n_prev_q;
  logic rd_wr_q;
  logic sel_n_q;
  logic strb_n_q;
  logic oe_q;
  logic [DATA_W-1:0] rdout_q;
  logic capture;
  logic done;

  wire busy = (state_q != H_IDLE);
  wire wr_ctrl = reg_we & (reg_addr == HOST_CTRL);
  wire start = wr_ctrl & reg_wdata[CTRL_START_BIT] & ~busy;
  wire cfg_zw = cfg_q[CFG_ZERO_WAIT_BIT] & ~cfg_q[CFG_TRANSPARENT_BIT];
  wire dir_write = ctrl_q[CTRL_WRITE_BIT];
  // Pin level chosen so that the device decodes the intended direction.
  wire read_high = is_read(1'b1, cfg_q[CFG_POLARITY_BIT],
                           cfg_q[CFG_TRANSPARENT_BIT], cfg_q[CFG_WIDE_BIT]);
  wire rd_wr_d = read_high ? ~dir_write : dir_write; // RULE_04 RULE_05

  always_comb begin
    state_d = state_q;
    capture = 1'b0;
    done = 1'b0;
    case (state_q)
      H_IDLE: begin
        if (start) begin
          state_d = H_SETUP;
        end
      end
      H_SETUP: begin
        state_d = H_STROBE;
      end
      H_STROBE: begin
        if (cfg_zw) begin
          if (cnt_q == CNT_W'(STROBE_CYC - 1)) begin
            capture = 1'b1;
            state_d = H_ZW_HI;
          end
        end else if (!hs_s) begin
          state_d = H_CAPTURE;
        end
      end
      H_CAPTURE: begin
        capture = 1'b1;
        state_d = H_RELEASE;
      end
      H_RELEASE: begin
        if (hs_s) begin
          done = 1'b1;
          state_d = H_IDLE;
        end
      end
      H_ZW_HI: begin
        if (hs_s) begin
          state_d = H_ZW_LO;
        end
      end
      H_ZW_LO: begin
        if (!hs_s) begin
          done = 1'b1;
          state_d = H_IDLE;
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
  end

  wire sel_d = (state_d == H_SETUP) | (state_d == H_STROBE) |
               (state_d == H_CAPTURE); // RULE_01
  wire strb_d = (state_d == H_STROBE) | (state_d == H_CAPTURE); // RULE_15
  wire dev_event = int_n_prev_q & ~int_n_s;
  wire [1:0] ev = {dev_event, done};
  wire [1:0] clr = (reg_we && reg_addr == HOST_INT_STATUS) ?
                   reg_wdata[1:0] : 2'b00;
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == HOST_CTRL) ? {13'h0000, ctrl_q} :
    (reg_addr == HOST_ADDR) ? {8'h00, addr_q} :
    (reg_addr == HOST_WDATA) ? wdata_q :
    (reg_addr == HOST_RDATA) ? rdata_q :
    (reg_addr == HOST_STATUS) ? {15'h0000, busy} :
    (reg_addr == HOST_INT_STATUS) ? {14'h0000, int_stat_q} :
    (reg_addr == HOST_INT_MASK) ? {14'h0000, int_mask_q} :
    {12'h000, cfg_q};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= H_IDLE;
      cnt_q <= '0;
      ctrl_q <= HOST_CTRL_RST;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      int_stat_q <= 2'b00;
      int_mask_q <= 2'b00;
      cfg_q <= HOST_CFG_RST;
      int_n_prev_q <= 1'b1;
      reg_rdata <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
      if (wr_ctrl && !busy) begin
        ctrl_q <= {reg_wdata[CTRL_MEM_BIT], reg_wdata[CTRL_WRITE_BIT], 1'b0};
      end
      if (reg_we && reg_addr == HOST_ADDR && !busy) begin
        addr_q <= reg_wdata[ADDR_W-1:0];
      end
      if (reg_we && reg_addr == HOST_WDATA && !busy) begin
        wdata_q <= reg_wdata;
      end
      if (reg_we && reg_addr == HOST_INT_MASK) begin
        int_mask_q <= reg_wdata[1:0];
      end
      if (reg_we && reg_addr == HOST_CFG && !busy) begin
        cfg_q <= reg_wdata[3:0];
      end
      if (capture && !dir_write) begin
        rdata_q <= data_s;
      end
      int_stat_q <= (int_stat_q & ~clr) | ev;
      int_n_prev_q <= int_n_s;
      reg_rdata <= reg_re ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_wr_q <= 1'b1;
      sel_n_q <= 1'b1;
      strb_n_q <= 1'b1;
      oe_q <= 1'b0;
      rdout_q <= '0;
    end else begin
      if (start) begin
        rd_wr_q <= read_high ? ~reg_wdata[CTRL_WRITE_BIT] :
                   reg_wdata[CTRL_WRITE_BIT];
      end else if (!busy) begin
        rd_wr_q <= rd_wr_d;
      end
      sel_n_q <= ~sel_d;
      strb_n_q <= ~strb_d;
      oe_q <= sel_d & dir_write & (state_d != H_SETUP | state_q == H_SETUP);
      rdout_q <= wdata_q;
    end
  end

  assign bus.select_n = sel_n_q;
  assign bus.data_strobe_n = strb_n_q;
  assign bus.mem_reg = ctrl_q[CTRL_MEM_BIT]; // RULE_03
  assign bus.rd_wr = rd_wr_q;
  assign bus.polarity_sel = cfg_q[CFG_POLARITY_BIT];
  assign bus.width_sel = cfg_q[CFG_WIDE_BIT]; // RULE_14
  assign bus.host_mode = cfg_q[CFG_TRANSPARENT_BIT]; // RULE_13
  assign bus.zero_wait = cfg_q[CFG_ZERO_WAIT_BIT];
  assign bus.addr = addr_q;
  assign bus.host_dout = rdout_q;
  assign bus.host_oe = oe_q;
  assign irq = |(int_stat_q & int_mask_q);
endmodule
`default_nettype wire

//--- test/host_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_assertions
  import host_port_pkg::*;
#(
  parameter int XFER_CYC = DEV_XFER_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic select_n,
  input wire logic data_strobe_n,
  input wire logic rd_wr,
  input wire logic polarity_sel,
  input wire logic width_sel,
  input wire logic host_mode,
  input wire logic zero_wait,
  input wire logic host_oe,
  input wire logic [DATA_W-1:0] dev_dout,
  input wire logic dev_oe,
  input wire logic buffer_drive_enable_n,
  input wire logic transfer_handshake,
  input wire logic int_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd_sense;
  int unsigned hi_q;
  assign rd_sense = (host_mode | ~width_sel | polarity_sel) ? rd_wr : ~rd_wr;
  // Counts consecutive high cycles of the handshake for the busy length.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_q <= 0;
    else hi_q <= transfer_handshake ? hi_q + 1 : 0;
  end
  property p_sync_delay;
    !zero_wait && $fell(data_strobe_n) |-> transfer_handshake [*2];
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("handshake answered before inputs were synchronized");
  property p_gate;
    !zero_wait && $fell(transfer_handshake) |-> !data_strobe_n && !select_n;
  endproperty
  a_gate: assert property (p_gate)
    else $error("handshake without select and strobe");
  property p_buf;
    !zero_wait && !$past(zero_wait, 8) && !transfer_handshake
      |-> !buffer_drive_enable_n;
  endproperty
  a_buf: assert property (p_buf)
    else $error("buffer enable high while ready");
  property p_rd_oe;
    (!zero_wait && !$past(zero_wait, 8) && rd_sense && !transfer_handshake)
      [*2] |-> dev_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe)
    else $error("read ready without driven data");
  property p_oe_dir;
    dev_oe |-> rd_sense && !host_oe;
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("device drives data outside a read");
  property p_zw_rise;
    zero_wait && $past(zero_wait, 8) && $rose(transfer_handshake)
      |-> data_strobe_n && $past(data_strobe_n);
  endproperty
  a_zw_rise: assert property (p_zw_rise)
    else $error("busy raised before strobe release");
  property p_zw_len;
    zero_wait && $past(zero_wait, 8) && $fell(transfer_handshake)
      |-> hi_q == XFER_CYC;
  endproperty
  a_zw_len: assert property (p_zw_len)
    else $error("busy length wrong");
  property p_pulse;
    $fell(int_n) |=> !int_n [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("interrupt low too short");
  property p_width8;
    dev_oe && !host_mode && !width_sel |-> dev_dout[15:8] == 8'h00;
  endproperty
  a_width8: assert property (p_width8)
    else $error("upper byte driven in 8-bit mode");
  property p_release;
    !zero_wait && $rose(data_strobe_n) |-> ##[1:6] transfer_handshake;
  endproperty
  a_release: assert property (p_release)
    else $error("handshake not returned after release");
endmodule
`default_nettype wire

//--- test/host_processor_port_signals_tb.sv
`timescale 1ns/10ps
`default_nettype none
module host_processor_port_signals_tb;
  import host_port_pkg::*;
  logic clk, resetn, reg_we, reg_re, irq, access_done;
  logic dir_seen, mem_seen, buf_seen;
  logic [2:0] reg_addr;
  logic [3:0] irq_event;
  logic [7:0] a;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, config2, q, d;
  logic [3:0] cfgs [8] = '{4'h6, 4'h2, 4'h0, 4'h4, 4'h3, 4'hE, 4'hA, 4'h8};
  int failures, tests_run, seed, n, dones;
  host_port_if bus_if ();
  host_port_device host_port_device_inst (.clk(clk), .resetn(resetn),
    .bus(bus_if), .irq_event(irq_event), .config2(config2),
    .access_done(access_done));
  host_port_controller host_port_controller_inst (.clk(clk),
    .resetn(resetn), .bus(bus_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq));
  host_port_assertions #(.XFER_CYC(DEV_XFER_CYC)) host_port_assertions_inst (
    .clk(clk), .resetn(resetn), .select_n(bus_if.select_n),
    .data_strobe_n(bus_if.data_strobe_n), .rd_wr(bus_if.rd_wr),
    .polarity_sel(bus_if.polarity_sel), .width_sel(bus_if.width_sel),
    .host_mode(bus_if.host_mode), .zero_wait(bus_if.zero_wait),
    .host_oe(bus_if.host_oe), .dev_dout(bus_if.dev_dout),
    .dev_oe(bus_if.dev_oe), .transfer_handshake(bus_if.transfer_handshake),
    .buffer_drive_enable_n(bus_if.buffer_drive_enable_n),
    .int_n(bus_if.int_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Records what the pins showed during the last strobed access.
  always @(posedge clk) begin
    if (!bus_if.data_strobe_n) begin
      dir_seen <= bus_if.rd_wr;
      mem_seen <= bus_if.mem_reg;
    end
    if (!bus_if.buffer_drive_enable_n) buf_seen <= 1'b1;
    if (access_done === 1'b1) dones <= dones + 1;
  end
  function automatic logic [15:0] exp_word(input logic [3:0] c,
                                           input logic [15:0] v);
    exp_word = (!c[0] && !c[1]) ? {8'h00, v[7:0]} : v;
  endfunction
  function automatic logic [15:0] dir_pin(input logic [3:0] c,
                                          input logic w);
    dir_pin = {15'h0000, (!c[0] && c[1] && !c[2]) ? w : !w};
  endfunction
  task automatic end_sim();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [15:0] v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] ad, output logic [15:0] v);
    reg_addr <= ad;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic xfer(input logic w, input logic m, input logic [7:0] ad,
                      input logic [15:0] v, output logic [15:0] r);
    logic [15:0] s;
    int k;
    int d0;
    buf_seen = 1'b0;
    d0 = dones;
    wr(HOST_ADDR, {8'h00, ad});
    wr(HOST_WDATA, v);
    wr(HOST_CTRL, {13'h0000, m, w, 1'b1});
    s = 16'h0001;
    k = 0;
    while (s[0] !== 1'b0 && k < 200) begin
      rd(HOST_STATUS, s);
      k++;
    end
    if (k >= 200) begin
      failures++;
      end_sim();
    end
    chk("access done", 16'(d0 + 1), 16'(dones));
    rd(HOST_RDATA, r);
  endtask
  task automatic wait_int();
    n = 0;
    // Look off the edge, so that a fall launched at this edge is seen now.
    #1;
    while (bus_if.int_n !== 1'b0 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      failures++;
      end_sim();
    end
  endtask
  initial begin
    resetn = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    irq_event = 4'h0;
    failures = 0;
    tests_run = 0;
    dones = 0;
    seed = 32'hb1400a7a;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd(HOST_CFG, q);
    chk("cfg reset", {12'h000, HOST_CFG_RST}, q);
    chk("int idle", 16'h0001, {15'h0000, bus_if.int_n});
    chk("buf idle", 16'h0001, {15'h0000, bus_if.buffer_drive_enable_n});
    foreach (cfgs[i]) begin
      wr(HOST_CFG, {12'h000, cfgs[i]});
      for (int k = 0; k < 4; k++) begin
        a = (k == 0) ? 8'hFF : 8'($random(seed));
        d = (k == 0) ? 16'hFFFF : 16'($random(seed));
        xfer(1'b1, 1'b1, a, d, q);
        chk("write dir", dir_pin(cfgs[i], 1'b1), {15'h0000, dir_seen});
        chk("space pin", 16'h0001, {15'h0000, mem_seen});
        chk("buf used", 16'h0001, {15'h0000, buf_seen});
        xfer(1'b0, 1'b1, a, 16'h0000, q);
        chk("read dir", dir_pin(cfgs[i], 1'b0), {15'h0000, dir_seen});
        chk("read back", exp_word(cfgs[i], d), q);
      end
    end
    wr(HOST_CFG, 16'h0006);
    xfer(1'b1, 1'b0, REG_CONFIG2, 16'h0008, q);
    chk("config2", 16'h0008, config2);
    chk("reg space pin", 16'h0000, {15'h0000, mem_seen});
    xfer(1'b1, 1'b1, REG_CONFIG2, 16'hFFFF, q);
    chk("config2 kept", 16'h0008, config2);
    xfer(1'b0, 1'b0, 8'h10, 16'hFFFF, q);
    chk("unmapped reg", 16'h0000, q);
    xfer(1'b1, 1'b0, REG_INT_MASK, 16'h000F, q);
    wr(HOST_INT_MASK, 16'h0002);
    irq_event <= 4'h1;
    @(posedge clk);
    irq_event <= 4'h0;
    wait_int();
    repeat (60) @(posedge clk);
    #1;
    chk("int level", 16'h0000, {15'h0000, bus_if.int_n});
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(HOST_INT_MASK, 16'h0000);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(HOST_INT_MASK, 16'h0002);
    xfer(1'b1, 1'b0, REG_INT_STATUS, 16'h000F, q);
    chk("int cleared", 16'h0001, {15'h0000, bus_if.int_n});
    wr(HOST_INT_STATUS, 16'h0002);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr(HOST_INT_MASK, 16'h0001);
    chk("irq done", 16'h0001, {15'h0000, irq});
    wr(HOST_INT_STATUS, 16'h0001);
    chk("done cleared", 16'h0000, {15'h0000, irq});
    xfer(1'b1, 1'b0, REG_CONFIG2, 16'h0000, q);
    irq_event <= 4'h4;
    @(posedge clk);
    irq_event <= 4'h0;
    wait_int();
    n = 0;
    while (bus_if.int_n === 1'b0 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pulse width", 16'h0032, 16'(n));
    end_sim();
  end
endmodule
`default_nettype wire
